// File: core/ebr_top.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: stores 8192 data bits, 9216 with parity
// R2: every shape from 8192x1 to 256x36
// R3: separate read and write enable per port
// R4: clock enable low freezes registers, array
// R5: ninth bit per byte is plain data
// R6: unselected bytes keep stored contents
// R7: byte selects default high, never cleared
// R8: byte selects only at widths 16/18/32/36
// R9: select bit n enables byte n
// R10: unselected show old, selected as configured
// R11: dual-port selects need byte-multiple widths
// R12: packed mode gives two half-size memories
// R13: stall holds the address register
// R14: each port has its own stall
// R15: stall low loads address normally
// R16: clear reaches only read address, outputs
// R17: clear zeroes outputs at once
// R18: user avoids read-address clear mid-read
// R19: power-up, clear, chip reset clear outputs
// R20: inputs registered, rising-edge operation only
// R21: read and write widths may differ
// R22: no 32/36 widths in true dual-port
// R23: read-during-write returns old or new
// R24: output register adds exactly one cycle
// R25: user avoids same-address writes from both
// R26: unregistered read data follows address edge
module ebr_top #(
    parameter int WIDTH_A = 18,
    parameter int WIDTH_B = 18
) (
    // clock and resets
    input  wire logic                         SYS_CLK,
    input  wire logic                         RESET_N,
    input  wire logic                         CHIP_WIDE_RESET_N,
    // first port
    input  wire logic                         FIRST_PORT_CLKEN_IN,
    input  wire logic                         FIRST_PORT_CLKEN_OUT,
    input  wire logic                         FIRST_PORT_RDEN,
    input  wire logic                         FIRST_PORT_WREN,
    input  wire logic                         FIRST_PORT_ADDRSTALL,
    input  wire logic                         FIRST_PORT_ACLR,
    input  wire logic [ebr_pkg::ADDR_W-1:0]   FIRST_PORT_ADDR,
    input  wire logic [WIDTH_A-1:0]           FIRST_PORT_DATA,
    input  wire logic [ebr_pkg::BE_W-1:0]     FIRST_PORT_BYTEENA,
    output logic      [WIDTH_A-1:0]           FIRST_PORT_Q,
    // second port
    input  wire logic                         SECOND_PORT_CLKEN_IN,
    input  wire logic                         SECOND_PORT_CLKEN_OUT,
    input  wire logic                         SECOND_PORT_RDEN,
    input  wire logic                         SECOND_PORT_WREN,
    input  wire logic                         SECOND_PORT_ADDRSTALL,
    input  wire logic                         SECOND_PORT_ACLR,
    input  wire logic [ebr_pkg::ADDR_W-1:0]   SECOND_PORT_ADDR,
    input  wire logic [WIDTH_B-1:0]           SECOND_PORT_DATA,
    input  wire logic [ebr_pkg::BE_W-1:0]     SECOND_PORT_BYTEENA,
    output logic      [WIDTH_B-1:0]           SECOND_PORT_Q,
    // axi4-lite slave
    input  wire logic [ebr_pkg::AXI_AW-1:0]   S_AXI_AWADDR,
    input  wire logic                         S_AXI_AWVALID,
    output logic                              S_AXI_AWREADY,
    input  wire logic [31:0]                  S_AXI_WDATA,
    input  wire logic [3:0]                   S_AXI_WSTRB,
    input  wire logic                         S_AXI_WVALID,
    output logic                              S_AXI_WREADY,
    output logic      [1:0]                   S_AXI_BRESP,
    output logic                              S_AXI_BVALID,
    input  wire logic                         S_AXI_BREADY,
    input  wire logic [ebr_pkg::AXI_AW-1:0]   S_AXI_ARADDR,
    input  wire logic                         S_AXI_ARVALID,
    output logic                              S_AXI_ARREADY,
    output logic      [31:0]                  S_AXI_RDATA,
    output logic      [1:0]                   S_AXI_RRESP,
    output logic                              S_AXI_RVALID,
    input  wire logic                         S_AXI_RREADY
);
    function automatic bit legal_w(input int w);
        case (w)
            1, 2, 4, 8, 9, 16, 18, 32, 36: legal_w = 1'b1;
            default: legal_w = 1'b0;
        endcase
    endfunction

    localparam bit NINE_A    = (WIDTH_A % 9) == 0;
    localparam bit NINE_B    = (WIDTH_B % 9) == 0;
    // mixed widths must stay in one byte family
    localparam bit SHAPE_OK  = legal_w(WIDTH_A) && legal_w(WIDTH_B) && (NINE_A == NINE_B); // R21
    localparam bit PACK_OK   = (WIDTH_A <= 18) && (WIDTH_B <= 18);
    localparam bit TDP_OK    = PACK_OK;
    localparam bit BYTE_MULT = ((WIDTH_A % 8 == 0) || NINE_A) && ((WIDTH_B % 8 == 0) || NINE_B);

    function automatic int cap_of(input bit nine);
        cap_of = nine ? ebr_pkg::CAP_X9 : ebr_pkg::CAP_X8; // R1
    endfunction

    function automatic int base_of(input logic [ebr_pkg::ADDR_W-1:0] a, input int w,
                                   input bit nine, input bit pk, input bit up);
        int depth;
        depth   = pk ? cap_of(nine) / (2 * w) : cap_of(nine) / w;
        base_of = (int'(a) % depth) * w + (up ? cap_of(nine) / 2 : 0); // R2 R12
    endfunction

    function automatic int lane_of(input int f, input bit nine);
        lane_of = nine ? f / 9 : f / 8;
    endfunction

    function automatic int bit_of(input int f, input bit nine);
        bit_of = nine ? f % 9 : f % 8;
    endfunction

    function automatic logic [ebr_pkg::DATA_W-1:0] bmask(input logic [ebr_pkg::BE_W-1:0] be,
                                                         input int w, input bit nine);
        bmask = '0;
        for (int i = 0; i < ebr_pkg::DATA_W; i++) begin
            if (i < w) begin
                bmask[i] = be[nine ? i / 9 : i / 8]; // R9
            end
        end
    endfunction

    function automatic bit hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = a[11:2] == ofs[11:2];
    endfunction

    function automatic bit mapped(input logic [11:0] a);
        mapped = hit(a, ebr_pkg::CFG_OFS) || hit(a, ebr_pkg::STAT_OFS) ||
                 hit(a, ebr_pkg::ADDR1_OFS) || hit(a, ebr_pkg::ADDR2_OFS);
    endfunction

    // 9-bit lanes: the ninth bit is ordinary storage, no parity logic
    logic [ebr_pkg::LANE_W-1:0]   mem [ebr_pkg::LANES]; // R5
    logic                         sys_rst_n;
    logic [ebr_pkg::CFG_W-1:0]    cfg_r;
    logic [2:0]                   stat;
    logic [ebr_pkg::ADDR_W-1:0]   addr_q_a;
    logic [ebr_pkg::ADDR_W-1:0]   addr_q_b;
    logic                         pk;
    logic                         opb;
    logic                         wr_a;
    logic                         wr_b;
    int                           base_a;
    int                           base_b;
    logic [ebr_pkg::BE_W-1:0]     be_a;
    logic [ebr_pkg::BE_W-1:0]     be_b;
    logic [ebr_pkg::DATA_W-1:0]   msk_a;
    logic [ebr_pkg::DATA_W-1:0]   msk_b;
    logic [ebr_pkg::DATA_W-1:0]   old_a;
    logic [ebr_pkg::DATA_W-1:0]   old_b;
    logic                         aw_have_r;
    logic                         w_have_r;
    logic [11:0]                  awaddr_r;
    logic [31:0]                  wdata_r;
    logic [3:0]                   wstrb_r;
    logic                         aw_hs;
    logic                         w_hs;
    logic                         ar_hs;
    logic                         wr_go;
    logic [11:0]                  wa;
    logic [31:0]                  wd;
    logic [3:0]                   ws;
    logic [31:0]                  rd_val;

    ebr_port_if ifa ();
    ebr_port_if ifb ();

    // chip-wide reset acts exactly like RESET_N
    assign sys_rst_n = RESET_N & CHIP_WIDE_RESET_N; // R19

    // separate instances give each port its own stall
    ebr_port #(.WIDTH(WIDTH_A)) u_first (
        .clk     (SYS_CLK),
        .rst_n   (sys_rst_n),
        .aclr    (FIRST_PORT_ACLR),
        .ce_in   (FIRST_PORT_CLKEN_IN),
        .ce_out  (FIRST_PORT_CLKEN_OUT),
        .re      (FIRST_PORT_RDEN),
        .we      (FIRST_PORT_WREN),
        .stall   (FIRST_PORT_ADDRSTALL), // R14 R15
        .oreg_en (cfg_r[ebr_pkg::CFG_OREG1]),
        .addr    (FIRST_PORT_ADDR),
        .din     (FIRST_PORT_DATA),
        .be      (FIRST_PORT_BYTEENA),
        .q       (FIRST_PORT_Q),
        .addr_q  (addr_q_a),
        .bus     (ifa.port)
    );

    ebr_port #(.WIDTH(WIDTH_B)) u_second (
        .clk     (SYS_CLK),
        .rst_n   (sys_rst_n),
        .aclr    (SECOND_PORT_ACLR),
        .ce_in   (SECOND_PORT_CLKEN_IN),
        .ce_out  (SECOND_PORT_CLKEN_OUT),
        .re      (SECOND_PORT_RDEN),
        .we      (SECOND_PORT_WREN),
        .stall   (SECOND_PORT_ADDRSTALL), // R14 R15
        .oreg_en (cfg_r[ebr_pkg::CFG_OREG2]),
        .addr    (SECOND_PORT_ADDR),
        .din     (SECOND_PORT_DATA),
        .be      (SECOND_PORT_BYTEENA),
        .q       (SECOND_PORT_Q),
        .addr_q  (addr_q_b),
        .bus     (ifb.port)
    );

    assign pk     = cfg_r[ebr_pkg::CFG_PACKED] && PACK_OK; // R12
    // second port writes are blocked when dual-port asks for a too-wide shape; its reads still run
    assign opb    = ifb.op && !(cfg_r[ebr_pkg::CFG_TDP] && !TDP_OK); // R22
    assign wr_a   = ifa.op && ifa.we; // R3
    assign wr_b   = opb && ifb.we; // R3
    assign base_a = base_of(ifa.addr, WIDTH_A, NINE_A, pk, 1'b0);
    assign base_b = base_of(ifb.addr, WIDTH_B, NINE_B, pk, pk);
    assign be_a   = (cfg_r[ebr_pkg::CFG_TDP] && !BYTE_MULT) ? '1 : ifa.be; // R11
    assign be_b   = (cfg_r[ebr_pkg::CFG_TDP] && !BYTE_MULT) ? '1 : ifb.be; // R11
    assign msk_a  = bmask(be_a, WIDTH_A, NINE_A);
    assign msk_b  = bmask(be_b, WIDTH_B, NINE_B);

    function automatic logic [ebr_pkg::DATA_W-1:0] rd_word(input int base, input int w,
                                                           input bit nine);
        rd_word = '0;
        for (int i = 0; i < ebr_pkg::DATA_W; i++) begin
            if (i < w) begin
                rd_word[i] = mem[lane_of(base + i, nine)][bit_of(base + i, nine)];
            end
        end
    endfunction

    // always_comb so the array contents are in the sensitivity
    always_comb begin
        old_a = rd_word(base_a, WIDTH_A, NINE_A);
        old_b = rd_word(base_b, WIDTH_B, NINE_B);
    end

    // other-port reads see the array before the edge, i.e. old data
    assign ifa.rdata = (ifa.we && cfg_r[ebr_pkg::CFG_NEWDATA]) ?
                       ((ifa.din & msk_a) | (old_a & ~msk_a)) : old_a; // R10 R23
    assign ifb.rdata = (ifb.we && cfg_r[ebr_pkg::CFG_NEWDATA]) ?
                       ((ifb.din & msk_b) | (old_b & ~msk_b)) : old_b; // R10 R23

    // second port written last; same-address collisions are undefined anyway
    always_ff @(posedge SYS_CLK) begin
        for (int i = 0; i < ebr_pkg::DATA_W; i++) begin
            if (wr_a && msk_a[i]) begin
                mem[lane_of(base_a + i, NINE_A)][bit_of(base_a + i, NINE_A)] <= ifa.din[i]; // R6
            end
            if (wr_b && msk_b[i]) begin
                mem[lane_of(base_b + i, NINE_B)][bit_of(base_b + i, NINE_B)] <= ifb.din[i]; // R25
            end
        end
    end

    assign stat          = {TDP_OK, PACK_OK, SHAPE_OK};
    assign aw_hs         = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_hs          = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_hs         = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_go         = (aw_have_r || aw_hs) && (w_have_r || w_hs);
    assign wa            = aw_have_r ? awaddr_r : S_AXI_AWADDR;
    assign wd            = w_have_r ? wdata_r : S_AXI_WDATA;
    assign ws            = w_have_r ? wstrb_r : S_AXI_WSTRB;
    assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_have_r && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_val        = hit(S_AXI_ARADDR, ebr_pkg::CFG_OFS)   ? 32'(cfg_r) :
                           hit(S_AXI_ARADDR, ebr_pkg::STAT_OFS)  ? 32'(stat) :
                           hit(S_AXI_ARADDR, ebr_pkg::ADDR1_OFS) ? 32'(addr_q_a) :
                           hit(S_AXI_ARADDR, ebr_pkg::ADDR2_OFS) ? 32'(addr_q_b) : 32'h0;

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            aw_have_r <= 1'b0;
            awaddr_r  <= 12'h000;
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end else if (aw_hs) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= S_AXI_AWADDR;
        end
    end

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            w_have_r <= 1'b0;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end else if (w_hs) begin
            w_have_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA;
            wstrb_r  <= S_AXI_WSTRB;
        end
    end

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= ebr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= mapped(wa) ? ebr_pkg::RESP_OKAY : ebr_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            cfg_r <= ebr_pkg::CFG_RST;
        end else if (wr_go && hit(wa, ebr_pkg::CFG_OFS) && ws[0]) begin
            cfg_r <= wd[ebr_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= ebr_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_val;
            S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? ebr_pkg::RESP_OKAY : ebr_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // helper state for checking masked writes one cycle on
    logic                         wa_q;
    int                           base_a_q;
    logic [ebr_pkg::DATA_W-1:0]   old_a_q;
    logic [ebr_pkg::DATA_W-1:0]   msk_a_q;
    logic [ebr_pkg::DATA_W-1:0]   now_a;

    always_ff @(posedge SYS_CLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            wa_q <= 1'b0;
        end else begin
            wa_q <= wr_a && !wr_b;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        base_a_q <= base_a;
        old_a_q  <= old_a;
        msk_a_q  <= msk_a;
    end

    always_comb begin
        now_a = rd_word(base_a_q, WIDTH_A, NINE_A);
    end

    chk_masked_kept: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R6
        wa_q |-> (now_a & ~msk_a_q) == (old_a_q & ~msk_a_q))
        else $error("unselected byte was overwritten");
    chk_masked_old_shown: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R10
        ifa.op && ifa.we && ifa.re |-> (ifa.rdata & ~msk_a) == (old_a & ~msk_a))
        else $error("unselected byte not showing old data");
    chk_rdw_new_data: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R23
        wr_a && cfg_r[ebr_pkg::CFG_NEWDATA] |-> (ifa.rdata & msk_a) == (ifa.din & msk_a))
        else $error("new data not returned during write");
    chk_aclr_zero: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R17
        FIRST_PORT_ACLR |-> FIRST_PORT_Q == '0)
        else $error("clear did not zero first port output");
    chk_reset_zero: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R19
        $rose(sys_rst_n) |-> FIRST_PORT_Q == '0 && SECOND_PORT_Q == '0)
        else $error("outputs not cleared by reset");
    chk_packed_halves: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R12
        pk |-> (base_a + WIDTH_A <= cap_of(NINE_A) / 2) && (base_b >= cap_of(NINE_B) / 2))
        else $error("packed memories overlap");
    chk_tdp_narrow: assert property (@(posedge SYS_CLK) disable iff (!sys_rst_n) // R22
        cfg_r[ebr_pkg::CFG_TDP] && !TDP_OK |-> !wr_b)
        else $error("second port active at a too-wide dual-port shape");
    cov_masked_write: cover property (@(posedge SYS_CLK) disable iff (!sys_rst_n)
        wr_a && msk_a != bmask('1, WIDTH_A, NINE_A));
    cov_new_data: cover property (@(posedge SYS_CLK) disable iff (!sys_rst_n)
        wr_a && ifa.re && cfg_r[ebr_pkg::CFG_NEWDATA]);
    cov_packed: cover property (@(posedge SYS_CLK) disable iff (!sys_rst_n)
        pk && wr_a && wr_b);
endmodule
`default_nettype wire

// File: inc/ebr_pkg.sv
package ebr_pkg;
    // array geometry
    localparam int          CAP_X8      = 8192;
    localparam int          CAP_X9      = 9216;
    localparam int          LANES       = 1024;
    localparam int          LANE_W      = 9;
    localparam int          ADDR_W      = 13;
    localparam int          DATA_W      = 36;
    localparam int          BE_W        = 4;
    // register bus
    localparam int          AXI_AW      = 12;
    localparam logic [11:0] CFG_OFS     = 12'h000;
    localparam logic [11:0] STAT_OFS    = 12'h004;
    localparam logic [11:0] ADDR1_OFS   = 12'h008;
    localparam logic [11:0] ADDR2_OFS   = 12'h00c;
    // configuration fields
    localparam int          CFG_W       = 5;
    localparam int          CFG_OREG1   = 0;
    localparam int          CFG_OREG2   = 1;
    localparam int          CFG_NEWDATA = 2;
    localparam int          CFG_PACKED  = 3;
    localparam int          CFG_TDP     = 4;
    localparam logic [4:0]  CFG_RST     = 5'h00;
    // status fields
    localparam int          STAT_SHAPE  = 0;
    localparam int          STAT_PACK   = 1;
    localparam int          STAT_TDP    = 2;
    // responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// File: inc/ebr_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ebr_port_if;
    logic                         op;
    logic                         re;
    logic                         we;
    logic [ebr_pkg::ADDR_W-1:0]   addr;
    logic [ebr_pkg::DATA_W-1:0]   din;
    logic [ebr_pkg::BE_W-1:0]     be;
    logic [ebr_pkg::DATA_W-1:0]   rdata;
    modport port (output op, re, we, addr, din, be, input rdata);
    modport core (input op, re, we, addr, din, be, output rdata);
endinterface
`default_nettype wire

// File: core/ebr_port.sv
`timescale 1ns/100ps
`default_nettype none
module ebr_port #(
    parameter int WIDTH = 18
) (
    // clock and clears
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         aclr,
    // user side
    input  wire logic                         ce_in,
    input  wire logic                         ce_out,
    input  wire logic                         re,
    input  wire logic                         we,
    input  wire logic                         stall,
    input  wire logic                         oreg_en,
    input  wire logic [ebr_pkg::ADDR_W-1:0]   addr,
    input  wire logic [WIDTH-1:0]             din,
    input  wire logic [ebr_pkg::BE_W-1:0]     be,
    output logic      [WIDTH-1:0]             q,
    output logic      [ebr_pkg::ADDR_W-1:0]   addr_q,
    // array side
    ebr_port_if.port                          bus
);
    localparam bit BE_OK = (WIDTH == 16) || (WIDTH == 18) || (WIDTH == 32) || (WIDTH == 36);

    logic                         clr_n;
    logic [ebr_pkg::ADDR_W-1:0]   addr_r;
    logic [ebr_pkg::ADDR_W-1:0]   addr_nxt;
    logic [ebr_pkg::DATA_W-1:0]   lat_r;
    logic [ebr_pkg::DATA_W-1:0]   out_r;

    // clear only reaches read address and outputs
    assign clr_n    = rst_n & ~aclr; // R16
    assign addr_nxt = stall ? addr_r : addr; // R13
    assign bus.op   = ce_in; // R4
    assign bus.re   = re; // R3
    assign bus.we   = we; // R3
    assign bus.addr = addr_nxt;
    assign bus.din  = ebr_pkg::DATA_W'(din);
    // narrow widths ignore the selects; no clear on this path
    assign bus.be   = BE_OK ? be : '1; // R8 R7
    assign addr_q   = addr_r;
    assign q        = oreg_en ? out_r[WIDTH-1:0] : lat_r[WIDTH-1:0];

    always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
            addr_r <= '0; // R16
        end else if (ce_in) begin
            addr_r <= addr_nxt; // R20
        end
    end

    // read data lands at the edge that takes the address
    always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
            lat_r <= '0; // R17
        end else if (ce_in && re) begin
            lat_r <= bus.rdata; // R26
        end
    end

    always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
            out_r <= '0; // R17
        end else if (ce_out) begin
            out_r <= lat_r; // R24
        end
    end

    chk_stall_hold: assert property (@(posedge clk) disable iff (!clr_n) // R13
        ce_in && stall |=> addr_r == $past(addr_r))
        else $error("address moved while stalled");
    chk_ce_freeze: assert property (@(posedge clk) disable iff (!clr_n) // R4
        !ce_in |=> $stable(lat_r) && $stable(addr_r))
        else $error("state moved without clock enable");
    chk_oreg_delay: assert property (@(posedge clk) disable iff (!clr_n) // R24
        ce_out |=> out_r == $past(lat_r))
        else $error("output register not one cycle behind");
    chk_read_edge: assert property (@(posedge clk) disable iff (!clr_n) // R26
        ce_in && re |=> lat_r == $past(bus.rdata))
        else $error("read data missing after address edge");
    cov_stall: cover property (@(posedge clk) disable iff (!clr_n)
        ce_in && stall && re ##1 ce_in && !stall);
endmodule
`default_nettype wire

// File: test/ebr_user.sv
`timescale 1ns/100ps
`default_nettype none
// user logic on one ram port; clears only between reads
module ebr_user #(
    parameter int W = 18
) (
    input  wire logic         clk,
    output logic              ce_in,
    output logic              re,
    output logic              we,
    output logic              stall,
    output logic              aclr,
    output logic [12:0]       addr,
    output logic [W-1:0]      data,
    output logic [3:0]        be
);
    initial begin
        {ce_in, re, we, stall, aclr} = 5'h10;
        {addr, data, be} = {13'h0000, {W{1'b0}}, 4'hf};
    end
    // one access per edge; enables dropped after to save power
    task automatic op(input logic r, input logic w, input logic [12:0] a,
                      input logic [W-1:0] d, input logic [3:0] b);
        @(posedge clk);
        {re, we, addr, data, be} <= {r, w, a, d, b};
        @(posedge clk);
        {re, we} <= 2'h0;
        data <= ~d;
    endtask
endmodule
`default_nettype wire

// File: test/tb_ebr_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ebr_top;
    logic clk, rst_n, cw_n, ceo, aw_v, w_v, b_r, ar_v, r_r, awr, wr, bv, arr, rv;
    logic ce1, re1, we1, st1, cl1, ce2, re2, we2, st2, cl2;
    logic [12:0] a1, a2;
    logic [17:0] d1, d2, q1, q2;
    logic [3:0]  b1, b2;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    int errors = 0, n_tests = 0;
    ebr_user u_p1 (.clk(clk), .ce_in(ce1), .re(re1), .we(we1), .stall(st1), .aclr(cl1),
                   .addr(a1), .data(d1), .be(b1));
    ebr_user u_p2 (.clk(clk), .ce_in(ce2), .re(re2), .we(we2), .stall(st2), .aclr(cl2),
                   .addr(a2), .data(d2), .be(b2));
    ebr_top u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .CHIP_WIDE_RESET_N(cw_n),
        .FIRST_PORT_CLKEN_IN(ce1), .FIRST_PORT_CLKEN_OUT(ceo), .FIRST_PORT_RDEN(re1),
        .FIRST_PORT_WREN(we1), .FIRST_PORT_ADDRSTALL(st1), .FIRST_PORT_ACLR(cl1),
        .FIRST_PORT_ADDR(a1), .FIRST_PORT_DATA(d1), .FIRST_PORT_BYTEENA(b1), .FIRST_PORT_Q(q1),
        .SECOND_PORT_CLKEN_IN(ce2), .SECOND_PORT_CLKEN_OUT(ceo), .SECOND_PORT_RDEN(re2),
        .SECOND_PORT_WREN(we2), .SECOND_PORT_ADDRSTALL(st2), .SECOND_PORT_ACLR(cl2),
        .SECOND_PORT_ADDR(a2), .SECOND_PORT_DATA(d2), .SECOND_PORT_BYTEENA(b2),
        .SECOND_PORT_Q(q2), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(r_r));
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n == 50) begin
            chk("timeout", 36'h0, 36'h1);
            final_report();
        end
    endtask
    // bus access; each channel held until its ready is seen at a rising edge
    task automatic ax(input logic w, input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic [31:0] sd;
        logic [1:0] sr;
        int n;
        @(posedge clk);
        if (w) {awa, wd, aw_v, w_v, b_r} <= {a, ed, 3'h7};
        else {ara, ar_v, r_r} <= {a, 2'h3};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            {sd, sr} = w ? {ed, br} : {rd, rr};
            if (aw_v && awr) aw_v <= 1'b0;
            if (w_v && wr) w_v <= 1'b0;
            if (ar_v && arr) ar_v <= 1'b0;
            if (w ? bv : rv) break;
        end
        {b_r, r_r} <= 2'h0;
        tmo(n);
        chk("bus data", ed, sd);
        chk("bus resp", er, sr);
    endtask
    task automatic t_bytes;
        u_p1.op(1'b0, 1'b1, 13'h0005, 18'h31234, 4'hf);
        u_p1.op(1'b1, 1'b1, 13'h0005, 18'h00abc, 4'h1);
        #1 chk("rdw old", 18'h31234, q1);
        u_p1.op(1'b1, 1'b0, 13'h0005, 18'h0, 4'hf);
        #1 chk("byte merge", 18'h312bc, q1);
        u_p2.op(1'b1, 1'b0, 13'h0005, 18'h0, 4'hf);
        #1 chk("other port", 18'h312bc, q2);
    endtask
    task automatic t_ce_stall;
        @(posedge clk) u_p1.ce_in <= 1'b0;
        u_p1.op(1'b0, 1'b1, 13'h0005, 18'h0, 4'hf);
        u_p1.ce_in <= 1'b1;
        u_p1.op(1'b1, 1'b0, 13'h0005, 18'h0, 4'hf);
        u_p1.stall <= 1'b1;
        u_p1.op(1'b1, 1'b0, 13'h0009, 18'h0, 4'hf);
        #1 chk("ce off", 18'h312bc, q1);
        @(posedge clk) u_p1.stall <= 1'b0;
    endtask
    task automatic t_oreg;
        ax(1'b1, 12'h000, 32'h1, 2'h0);
        ax(1'b0, 12'h000, 32'h1, 2'h0);
        ax(1'b0, 12'h010, 32'h0, 2'h2);
        u_p1.op(1'b0, 1'b1, 13'h0007, 18'h2468a, 4'hf);
        u_p1.op(1'b1, 1'b0, 13'h0007, 18'h0, 4'hf);
        #1 chk("oreg early", 18'h312bc, q1);
        @(posedge clk) #1 chk("oreg late", 18'h2468a, q1);
        @(posedge clk) u_p1.aclr <= 1'b1;
        #1 chk("aclr", 18'h0, q1);
        @(posedge clk) u_p1.aclr <= 1'b0;
        @(posedge clk) cw_n <= 1'b0;
        #1 chk("chip reset", 18'h0, q2);
        @(posedge clk) cw_n <= 1'b1;
        ax(1'b0, 12'h000, 32'h0, 2'h0);
        ax(1'b0, 12'h004, 32'h7, 2'h0);
        ax(1'b1, 12'h000, 32'h4, 2'h0);
        // new-data mode: selected byte new, unselected byte old
        u_p1.op(1'b1, 1'b1, 13'h0005, 18'h3fe00, 4'h2);
        #1 chk("rdw new", 18'h3febc, q1);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst_n, cw_n, ceo, aw_v, w_v, b_r, ar_v, r_r} = 8'h60;
        {awa, ara, wd} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("reset q", 18'h0, q1);
        t_bytes();
        t_ce_stall();
        t_oreg();
        final_report();
    end
endmodule
`default_nettype wire
